// >>> core/wps_regs.vh
// Register offsets, field positions, reset values and frame counts of the path overhead block.
`ifndef WPS_REGS_VH
`define WPS_REGS_VH
`define WPS_ADDR_W 4
`define WPS_DATA_W 16
`define WPS_PATH_MODE_CONTROL 4'h0
`define WPS_TRANSMIT_CONTROL_TWO 4'h1
`define WPS_USER_CHANNEL_BYTE 4'h2
`define WPS_MULTIFRAME_BYTE 4'h3
`define WPS_GROWTH_BYTE_THREE 4'h4
`define WPS_GROWTH_BYTE_FOUR 4'h5
`define WPS_TANDEM_BYTE 4'h6
`define WPS_PATH_STATUS_THREE 4'h7
`define WPS_EVENT_PENDING_ONE 4'h8
`define WPS_EVENT_PENDING_TWO 4'h9
`define WPS_EVENT_LIVE_TWO 4'hA
`define WPS_ROUTE_A_MASK_ONE 4'hB
`define WPS_ROUTE_B_MASK_ONE 4'hC
`define WPS_ROUTE_A_MASK_TWO 4'hD
`define WPS_ROUTE_B_MASK_TWO 4'hE
// Field positions.
`define WPS_RX_ENHANCED_RDI_SELECT 0
`define WPS_TX_ENHANCED_RDI_SELECT 0
`define WPS_FORCE_TRACE_MISMATCH 1
`define WPS_PAYLOAD_BIT 0
`define WPS_SERVER_BIT 1
`define WPS_FAR_RDI_BIT 0
`define WPS_CONNECTIVITY_BIT 1
`define WPS_UNEQUIPPED_BIT 2
// Reset values.
`define WPS_MODE_RESET 1'b1
`define WPS_OVERHEAD_BYTE_RESET 8'h00
// G1 defect codes, bits 5 to 7.
`define WPS_CODE_NONE_RDI 3'h0
`define WPS_CODE_RDI 3'h4
`define WPS_CODE_RDI_ALT 3'h7
`define WPS_CODE_NONE 3'h1
`define WPS_CODE_PAYLOAD 3'h2
`define WPS_CODE_SERVER 3'h5
`define WPS_CODE_CONNECTIVITY 3'h6
// Frame counts, error count limit and signal label values.
`define WPS_DEFECT_FRAMES 10
`define WPS_LABEL_FRAMES 5
`define WPS_REI_MAX 4'h8
`define WPS_LABEL_UNEQUIPPED 8'h00
`define WPS_LABEL_RESET 8'hFF
`endif

// >>> core/wps_frame_accept.v
// Accepts a per-frame value once it has repeated for a set number of consecutive frames.
`timescale 1ns/100ps
`default_nettype none
module wps_frame_accept #(
   parameter WIDTH = 3,
   parameter COUNT = 10,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   input wire sys_clk,
   input wire arst_n,
   input wire frameStb,
   input wire [WIDTH-1:0] frameValue,
   output reg [WIDTH-1:0] accepted_q
);
   reg [WIDTH-1:0] last_q;
   reg [3:0] run_q;
   reg [3:0] run_d;
   localparam [3:0] RUN_MAX = COUNT[3:0];

   // A change of value restarts the run; the run stops at the acceptance count.
   always @* begin
      if (frameValue != last_q) begin
         run_d = 4'h1;
      end else if (run_q < RUN_MAX) begin
         run_d = run_q + 4'h1;
      end else begin
         run_d = run_q;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_q <= RESET_VALUE;
         run_q <= 4'h0;
         accepted_q <= RESET_VALUE;
      end else if (frameStb) begin
         last_q <= frameValue;
         run_q <= run_d;
         if (run_d == RUN_MAX) begin
            accepted_q <= frameValue;
         end
      end
   end
endmodule // wps_frame_accept
`default_nettype wire

// >>> core/wps_path_overhead.v
// Path status byte generation and checking with programmable path overhead bytes.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "wps_regs.vh"
module wps_path_overhead (
   input wire sys_clk,
   input wire arst_n,
   input wire [`WPS_ADDR_W-1:0] regAddr,
   input wire [`WPS_DATA_W-1:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [`WPS_DATA_W-1:0] regRdData_q,
   input wire rxFrameStb,
   input wire [7:0] rxG1,
   input wire [7:0] rxC2,
   input wire b3CountStb,
   input wire [3:0] b3Count,
   input wire pathAis,
   input wire lossOfPointer,
   input wire labelMismatch,
   input wire codeGroupLoss,
   input wire txFrameStb,
   output reg [7:0] txG1_q,
   output reg [7:0] txF2_q,
   output reg [7:0] txH4_q,
   output reg [7:0] txZ3_q,
   output reg [7:0] txZ4_q,
   output reg [7:0] txN1_q,
   output wire interrupt_out_a,
   output wire interrupt_out_b
);
   reg rxEnhanced_q;
   reg txEnhanced_q;
   reg forceTraceMismatch_q;
   reg [7:0] userChannel_q;
   reg [7:0] multiframe_q;
   reg [7:0] growthThree_q;
   reg [7:0] growthFour_q;
   reg [7:0] tandem_q;
   reg [1:0] statusThree_q;
   reg [1:0] statusThree_d;
   reg [1:0] pendingOne_q;
   reg [1:0] pendingOne_d;
   reg [1:0] pendingTwo_q;
   reg [1:0] pendingTwo_d;
   reg [1:0] routeAOne_q;
   reg [1:0] routeBOne_q;
   reg [2:0] routeATwo_q;
   reg [2:0] routeBTwo_q;
   reg [2:0] liveTwo_q;
   reg [2:0] rxClass;
   reg [2:0] txCode;
   reg [3:0] reiHold_q;
   reg reiValid_q;
   reg [3:0] reiClamped;
   reg [3:0] reiSend;
   reg [3:0] liveOld_q;
   wire [2:0] acceptedCode;
   wire [7:0] acceptedLabel;
   wire farRdiLive;
   wire payloadLive;
   wire serverLive;
   wire connLive;
   wire unequipped;
   wire serverTrig;
   wire connTrig;
   wire payloadTrig;
   wire rdStatus;
   wire rdPendOne;
   wire rdPendTwo;
   wire [3:0] liveNow;
   wire [3:0] riseNow;

   // Receive G1 classification: RDI mode keeps only bit five; enhanced mode folds
   // every non-defect code onto one value so clean frames form one unbroken run.
   always @* begin
      if (!rxEnhanced_q) begin
         // Bit five of the byte is bit 3 here; the spare bit is never looked at.
         rxClass = rxG1[3] ? `WPS_CODE_RDI : `WPS_CODE_NONE_RDI;
      end else begin
         case (rxG1[3:1])
            `WPS_CODE_PAYLOAD: rxClass = `WPS_CODE_PAYLOAD;
            `WPS_CODE_SERVER: rxClass = `WPS_CODE_SERVER;
            `WPS_CODE_CONNECTIVITY: rxClass = `WPS_CODE_CONNECTIVITY;
            default: rxClass = `WPS_CODE_NONE;
         endcase
      end
   end

   // Ten identical frames are needed both to declare and to clear.
   wps_frame_accept #(
      .WIDTH(3),
      .COUNT(`WPS_DEFECT_FRAMES),
      .RESET_VALUE(`WPS_CODE_NONE)
   ) u_g1Accept (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .frameStb(rxFrameStb),
      .frameValue(rxClass),
      .accepted_q(acceptedCode)
   );

   // A zero signal label seen in five consecutive frames marks the path unequipped.
   wps_frame_accept #(
      .WIDTH(8),
      .COUNT(`WPS_LABEL_FRAMES),
      .RESET_VALUE(`WPS_LABEL_RESET)
   ) u_c2Accept (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .frameStb(rxFrameStb),
      .frameValue(rxC2),
      .accepted_q(acceptedLabel)
   );

   assign unequipped = (acceptedLabel == `WPS_LABEL_UNEQUIPPED);
   assign farRdiLive = !rxEnhanced_q && (acceptedCode == `WPS_CODE_RDI);
   assign payloadLive = rxEnhanced_q && (acceptedCode == `WPS_CODE_PAYLOAD);
   assign serverLive = rxEnhanced_q && (acceptedCode == `WPS_CODE_SERVER);
   assign connLive = rxEnhanced_q && (acceptedCode == `WPS_CODE_CONNECTIVITY);
   assign liveNow = {connLive, serverLive, payloadLive, farRdiLive};
   assign riseNow = liveNow & ~liveOld_q;

   // Read strobes on the status three and event pending registers clear what they return.
   assign rdStatus = regRd && (regAddr == `WPS_PATH_STATUS_THREE);
   assign rdPendOne = regRd && (regAddr == `WPS_EVENT_PENDING_ONE);
   assign rdPendTwo = regRd && (regAddr == `WPS_EVENT_PENDING_TWO);

   // A new event in the cycle of the clearing read stays set.
   always @* begin
      statusThree_d = statusThree_q & ~{2{rdStatus}};
      statusThree_d[`WPS_PAYLOAD_BIT] = statusThree_d[`WPS_PAYLOAD_BIT] | payloadLive;
      statusThree_d[`WPS_SERVER_BIT] = statusThree_d[`WPS_SERVER_BIT] | serverLive;
      pendingOne_d = pendingOne_q & ~{2{rdPendOne}};
      pendingOne_d[`WPS_PAYLOAD_BIT] = pendingOne_d[`WPS_PAYLOAD_BIT] | riseNow[1];
      pendingOne_d[`WPS_SERVER_BIT] = pendingOne_d[`WPS_SERVER_BIT] | riseNow[2];
      pendingTwo_d = pendingTwo_q & ~{2{rdPendTwo}};
      pendingTwo_d[`WPS_FAR_RDI_BIT] = pendingTwo_d[`WPS_FAR_RDI_BIT] | riseNow[0];
      pendingTwo_d[`WPS_CONNECTIVITY_BIT] = pendingTwo_d[`WPS_CONNECTIVITY_BIT] | riseNow[3];
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         statusThree_q <= 2'h0;
         pendingOne_q <= 2'h0;
         pendingTwo_q <= 2'h0;
         liveOld_q <= 4'h0;
         liveTwo_q <= 3'h0;
      end else begin
         statusThree_q <= statusThree_d;
         pendingOne_q <= pendingOne_d;
         pendingTwo_q <= pendingTwo_d;
         liveOld_q <= liveNow;
         liveTwo_q <= {unequipped, connLive, farRdiLive};
      end
   end

   // Connectivity events share the far RDI routing bits.
   assign interrupt_out_a = |(pendingOne_q & routeAOne_q)
      | (pendingTwo_q[`WPS_FAR_RDI_BIT] & routeATwo_q[`WPS_FAR_RDI_BIT])
      | (pendingTwo_q[`WPS_CONNECTIVITY_BIT] & routeATwo_q[`WPS_FAR_RDI_BIT]);
   assign interrupt_out_b = |(pendingOne_q & routeBOne_q)
      | (pendingTwo_q[`WPS_FAR_RDI_BIT] & routeBTwo_q[`WPS_FAR_RDI_BIT])
      | (pendingTwo_q[`WPS_CONNECTIVITY_BIT] & routeBTwo_q[`WPS_FAR_RDI_BIT]);

   // Software writes to the control, byte and mask registers.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxEnhanced_q <= `WPS_MODE_RESET;
         txEnhanced_q <= `WPS_MODE_RESET;
         forceTraceMismatch_q <= 1'b0;
         userChannel_q <= `WPS_OVERHEAD_BYTE_RESET;
         multiframe_q <= `WPS_OVERHEAD_BYTE_RESET;
         growthThree_q <= `WPS_OVERHEAD_BYTE_RESET;
         growthFour_q <= `WPS_OVERHEAD_BYTE_RESET;
         tandem_q <= `WPS_OVERHEAD_BYTE_RESET;
         routeAOne_q <= 2'h0;
         routeBOne_q <= 2'h0;
         routeATwo_q <= 3'h0;
         routeBTwo_q <= 3'h0;
      end else if (regWr) begin
         case (regAddr)
            `WPS_PATH_MODE_CONTROL: begin
               rxEnhanced_q <= regWrData[`WPS_RX_ENHANCED_RDI_SELECT];
            end
            `WPS_TRANSMIT_CONTROL_TWO: begin
               txEnhanced_q <= regWrData[`WPS_TX_ENHANCED_RDI_SELECT];
               forceTraceMismatch_q <= regWrData[`WPS_FORCE_TRACE_MISMATCH];
            end
            `WPS_USER_CHANNEL_BYTE: userChannel_q <= regWrData[7:0];
            `WPS_MULTIFRAME_BYTE: multiframe_q <= regWrData[7:0];
            `WPS_GROWTH_BYTE_THREE: growthThree_q <= regWrData[7:0];
            `WPS_GROWTH_BYTE_FOUR: growthFour_q <= regWrData[7:0];
            `WPS_TANDEM_BYTE: tandem_q <= regWrData[7:0];
            `WPS_ROUTE_A_MASK_ONE: routeAOne_q <= regWrData[1:0];
            `WPS_ROUTE_B_MASK_ONE: routeBOne_q <= regWrData[1:0];
            `WPS_ROUTE_A_MASK_TWO: routeATwo_q <= regWrData[2:0];
            `WPS_ROUTE_B_MASK_TWO: routeBTwo_q <= regWrData[2:0];
            default: begin
            end
         endcase
      end
   end

   // Read data stand in the cycle after the read strobe; unmapped reads return zero.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData_q <= 16'h0000;
      end else if (regRd) begin
         case (regAddr)
            `WPS_PATH_MODE_CONTROL: regRdData_q <= {15'h0000, rxEnhanced_q};
            `WPS_TRANSMIT_CONTROL_TWO: regRdData_q <= {14'h0000, forceTraceMismatch_q, txEnhanced_q};
            `WPS_USER_CHANNEL_BYTE: regRdData_q <= {8'h00, userChannel_q};
            `WPS_MULTIFRAME_BYTE: regRdData_q <= {8'h00, multiframe_q};
            `WPS_GROWTH_BYTE_THREE: regRdData_q <= {8'h00, growthThree_q};
            `WPS_GROWTH_BYTE_FOUR: regRdData_q <= {8'h00, growthFour_q};
            `WPS_TANDEM_BYTE: regRdData_q <= {8'h00, tandem_q};
            `WPS_PATH_STATUS_THREE: regRdData_q <= {14'h0000, statusThree_q};
            `WPS_EVENT_PENDING_ONE: regRdData_q <= {14'h0000, pendingOne_q};
            `WPS_EVENT_PENDING_TWO: regRdData_q <= {14'h0000, pendingTwo_q};
            `WPS_EVENT_LIVE_TWO: regRdData_q <= {13'h0000, liveTwo_q};
            `WPS_ROUTE_A_MASK_ONE: regRdData_q <= {14'h0000, routeAOne_q};
            `WPS_ROUTE_B_MASK_ONE: regRdData_q <= {14'h0000, routeBOne_q};
            `WPS_ROUTE_A_MASK_TWO: regRdData_q <= {13'h0000, routeATwo_q};
            `WPS_ROUTE_B_MASK_TWO: regRdData_q <= {13'h0000, routeBTwo_q};
            default: regRdData_q <= 16'h0000;
         endcase
      end
   end

   // Transmit defect code selection in priority order.
   assign serverTrig = pathAis | lossOfPointer;
   assign connTrig = unequipped | forceTraceMismatch_q;
   assign payloadTrig = labelMismatch | codeGroupLoss;

   always @* begin
      if (!txEnhanced_q) begin
         txCode = serverTrig ? `WPS_CODE_RDI : `WPS_CODE_NONE_RDI;
      end else if (serverTrig) begin
         txCode = `WPS_CODE_SERVER;
      end else if (connTrig) begin
         txCode = `WPS_CODE_CONNECTIVITY;
      end else if (payloadTrig) begin
         txCode = `WPS_CODE_PAYLOAD;
      end else begin
         txCode = `WPS_CODE_NONE;
      end
   end

   // One held count hands errors from receive to transmit; an empty slot sends zero.
   always @* begin
      reiClamped = (b3Count > `WPS_REI_MAX) ? `WPS_REI_MAX : b3Count;
      reiSend = reiValid_q ? reiHold_q : 4'h0;
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reiHold_q <= 4'h0;
         reiValid_q <= 1'b0;
      end else if (txFrameStb) begin
         // A count arriving as the slot drains takes the slot at once.
         reiValid_q <= b3CountStb;
         reiHold_q <= reiClamped;
      end else if (b3CountStb && !reiValid_q) begin
         reiValid_q <= 1'b1;
         reiHold_q <= reiClamped;
      end
      // A count arriving while the slot is full is discarded.
   end

   // All transmit overhead bytes change together at the frame strobe.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         txG1_q <= {4'h0, `WPS_CODE_NONE, 1'b0};
         txF2_q <= `WPS_OVERHEAD_BYTE_RESET;
         txH4_q <= `WPS_OVERHEAD_BYTE_RESET;
         txZ3_q <= `WPS_OVERHEAD_BYTE_RESET;
         txZ4_q <= `WPS_OVERHEAD_BYTE_RESET;
         txN1_q <= `WPS_OVERHEAD_BYTE_RESET;
      end else if (txFrameStb) begin
         txG1_q <= {reiSend, txCode, 1'b0};
         txF2_q <= userChannel_q;
         txH4_q <= multiframe_q;
         txZ3_q <= growthThree_q;
         txZ4_q <= growthFour_q;
         txN1_q <= tandem_q;
      end
   end
endmodule // wps_path_overhead
`default_nettype wire

// >>> test/wps_path_overhead_chk.sv
// Port-level assertions for the path overhead block.
`timescale 1ns/100ps
`default_nettype none
`include "wps_regs.vh"
module wps_path_overhead_chk (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [`WPS_ADDR_W-1:0] regAddr,
   input wire logic regRd,
   input wire logic [`WPS_DATA_W-1:0] regRdData_q,
   input wire logic txFrameStb,
   input wire logic pathAis,
   input wire logic lossOfPointer,
   input wire logic [7:0] txG1_q,
   input wire logic [7:0] txF2_q,
   input wire logic [7:0] txH4_q,
   input wire logic [7:0] txZ3_q,
   input wire logic [7:0] txZ4_q,
   input wire logic [7:0] txN1_q,
   input wire logic interrupt_out_a,
   input wire logic interrupt_out_b
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence sTake;
      txFrameStb ##1 1'b1;
   endsequence
   sequence sServerTake;
      (pathAis || lossOfPointer) && txFrameStb;
   endsequence
   chk_reset_values: assert property ($rose(arst_n) |-> txG1_q == 8'h02 && txF2_q == 8'h00
      && !interrupt_out_a && !interrupt_out_b) else $error("Reset values wrong.");
   chk_frame_hold: assert property (!txFrameStb |=> $stable({txG1_q, txF2_q, txH4_q}))
      else $error("Transmit bytes moved between frames.");
   chk_growth_hold: assert property (!txFrameStb |=> $stable({txZ3_q, txZ4_q, txN1_q}))
      else $error("Growth bytes moved between frames.");
   chk_spare_zero: assert property (sTake |-> txG1_q[0] == 1'b0)
      else $error("Spare bit sent high.");
   chk_rei_range: assert property (sTake |-> txG1_q[7:4] <= `WPS_REI_MAX)
      else $error("Error count above eight.");
   chk_code_legal: assert property (sTake |-> txG1_q[3:1] inside {3'h0, 3'h4, 3'h1, 3'h2,
      3'h5, 3'h6}) else $error("Illegal defect code sent.");
   chk_server_code: assert property (sServerTake |=> txG1_q[3:1] inside
      {`WPS_CODE_SERVER, `WPS_CODE_RDI}) else $error("Server defect not sent.");
   chk_clean_code: assert property (!pathAis && !lossOfPointer && txFrameStb |=>
      !(txG1_q[3:1] inside {`WPS_CODE_SERVER, `WPS_CODE_RDI})) else $error("False server code.");
   chk_read_hold: assert property (!regRd |=> $stable(regRdData_q))
      else $error("Read data moved without a read.");
   chk_unmapped_zero: assert property (regRd && regAddr == 4'hF |=> regRdData_q == 16'h0000)
      else $error("Unmapped read not zero.");
endmodule // wps_path_overhead_chk
bind wps_path_overhead wps_path_overhead_chk i_wps_path_overhead_chk (
   .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regRd(regRd),
   .regRdData_q(regRdData_q), .txFrameStb(txFrameStb), .pathAis(pathAis),
   .lossOfPointer(lossOfPointer), .txG1_q(txG1_q), .txF2_q(txF2_q), .txH4_q(txH4_q),
   .txZ3_q(txZ3_q), .txZ4_q(txZ4_q), .txN1_q(txN1_q),
   .interrupt_out_a(interrupt_out_a), .interrupt_out_b(interrupt_out_b)
);
`default_nettype wire

// >>> test/wps_far_end.sv
// Far-end path terminating equipment that sends G1, C2 and B3 error counts.
`timescale 1ns/100ps
`default_nettype none
module wps_far_end (
   input wire logic sys_clk,
   output logic rxFrameStb,
   output logic [7:0] rxG1,
   output logic [7:0] rxC2,
   output logic b3CountStb,
   output logic [3:0] b3Count
);
   initial begin
      rxFrameStb = 1'b0;
      rxG1 = 8'h00;
      rxC2 = 8'h00;
      b3CountStb = 1'b0;
      b3Count = 4'h0;
   end
   // Sends frames with a fixed count and a high spare bit; lines invert between frames.
   task automatic frames(input logic [2:0] code, input logic [7:0] label, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         rxFrameStb <= 1'b1;
         rxG1 <= {4'h5, code, 1'b1};
         rxC2 <= label;
         @(posedge sys_clk);
         rxFrameStb <= 1'b0;
         rxG1 <= ~{4'h5, code, 1'b1};
         rxC2 <= ~label;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   // Hands one block error count across to the transmit side.
   task automatic count(input logic [3:0] c);
      @(posedge sys_clk);
      b3CountStb <= 1'b1;
      b3Count <= c;
      @(posedge sys_clk);
      b3CountStb <= 1'b0;
      b3Count <= ~c;
   endtask
endmodule // wps_far_end
`default_nettype wire

// >>> test/wps_path_overhead_test.sv
// Self-checking bench for the path overhead block.
`timescale 1ns/100ps
`default_nettype none
`include "wps_regs.vh"
module wps_path_overhead_test;
   logic sys_clk;
   logic arst_n;
   logic [`WPS_ADDR_W-1:0] regAddr;
   logic [`WPS_DATA_W-1:0] regWrData;
   logic [`WPS_DATA_W-1:0] regRdData_q;
   logic regWr, regRd, rxFrameStb, b3CountStb, txFrameStb, intA, intB;
   logic pathAis, lossOfPointer, labelMismatch, codeGroupLoss;
   logic [7:0] rxG1, rxC2, txG1_q, txF2_q, txH4_q, txZ3_q, txZ4_q, txN1_q;
   logic [3:0] b3Count;
   logic [7:0] prio [7];
   int fails;
   int comparisons;
   wps_path_overhead i_wps_path_overhead (.sys_clk(sys_clk), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData_q(regRdData_q), .rxFrameStb(rxFrameStb), .rxG1(rxG1), .rxC2(rxC2),
      .b3CountStb(b3CountStb), .b3Count(b3Count), .pathAis(pathAis),
      .lossOfPointer(lossOfPointer), .labelMismatch(labelMismatch),
      .codeGroupLoss(codeGroupLoss), .txFrameStb(txFrameStb), .txG1_q(txG1_q),
      .txF2_q(txF2_q), .txH4_q(txH4_q), .txZ3_q(txZ3_q), .txZ4_q(txZ4_q),
      .txN1_q(txN1_q), .interrupt_out_a(intA), .interrupt_out_b(intB));
   wps_far_end i_wps_far_end (.sys_clk(sys_clk), .rxFrameStb(rxFrameStb), .rxG1(rxG1),
      .rxC2(rxC2), .b3CountStb(b3CountStb), .b3Count(b3Count));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic wrap_up;
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 chk(regRdData_q & m, e);
   endtask
   task automatic tick;
      @(posedge sys_clk);
      txFrameStb <= 1'b1;
      @(posedge sys_clk);
      txFrameStb <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (50000) @(posedge sys_clk);
      fails++;
      wrap_up;
   end
   initial begin
      {arst_n, regAddr, regWrData, regWr, regRd, txFrameStb} = '0;
      {pathAis, lossOfPointer, labelMismatch, codeGroupLoss} = 4'h0;
      fails = 0;
      comparisons = 0;
      prio = '{8'h01, 8'h22, 8'h12, 8'h0E, 8'h3E, 8'hBD, 8'h45};
      repeat (4) @(posedge sys_clk);
      chk({8'h00, txG1_q}, 16'h0002);
      arst_n <= 1'b1;
      rdChk(`WPS_PATH_MODE_CONTROL, 16'h0001, 16'h0001);
      rdChk(`WPS_TRANSMIT_CONTROL_TWO, 16'h0003, 16'h0001);
      rdChk(4'hF, 16'hFFFF, 16'h0000);
      for (int a = 2; a < 7; a++) begin
         rdChk(a[3:0], 16'h00FF, 16'h0000);
         wr(a[3:0], 16'h00A0 + a[15:0]);
      end
      tick;
      chk({txF2_q, txH4_q}, 16'hA2A3);
      chk({txZ3_q, txZ4_q}, 16'hA4A5);
      wr(`WPS_TANDEM_BYTE, 16'h005A);
      chk({8'h00, txN1_q}, 16'h00A6);
      tick;
      chk({8'h00, txN1_q}, 16'h005A);
      i_wps_far_end.count(4'h3);
      tick;
      chk({8'h00, txG1_q}, 16'h0032);
      tick;
      chk({8'h00, txG1_q}, 16'h0002);
      i_wps_far_end.count(4'h5);
      i_wps_far_end.count(4'h6);
      tick;
      chk({8'h00, txG1_q}, 16'h0052);
      i_wps_far_end.count(4'hC);
      tick;
      chk({8'h00, txG1_q}, 16'h0082);
      for (int i = 0; i < 7; i++) begin
         @(posedge sys_clk);
         {pathAis, lossOfPointer, labelMismatch, codeGroupLoss} <= prio[i][7:4];
         wr(`WPS_TRANSMIT_CONTROL_TWO, {14'h0000, prio[i][3], 1'b1});
         tick;
         chk({13'h0000, txG1_q[3:1]}, {13'h0000, prio[i][2:0]});
      end
      wr(`WPS_TRANSMIT_CONTROL_TWO, 16'h0000);
      tick;
      chk({8'h00, txG1_q}, 16'h0008);
      @(posedge sys_clk);
      lossOfPointer <= 1'b0;
      tick;
      chk({8'h00, txG1_q}, 16'h0000);
      wr(`WPS_TRANSMIT_CONTROL_TWO, 16'h0001);
      i_wps_far_end.frames(3'h1, 8'h00, 4);
      tick;
      chk({8'h00, txG1_q}, 16'h0002);
      i_wps_far_end.frames(3'h1, 8'h00, 1);
      tick;
      chk({8'h00, txG1_q}, 16'h000C);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0004, 16'h0004);
      i_wps_far_end.frames(3'h1, 8'h1A, 5);
      wr(`WPS_ROUTE_A_MASK_ONE, 16'h0002);
      wr(`WPS_ROUTE_B_MASK_ONE, 16'h0001);
      wr(`WPS_ROUTE_A_MASK_TWO, 16'h0001);
      wr(`WPS_ROUTE_B_MASK_TWO, 16'h0001);
      i_wps_far_end.frames(3'h5, 8'h1A, 9);
      i_wps_far_end.frames(3'h1, 8'h1A, 1);
      i_wps_far_end.frames(3'h5, 8'h1A, 9);
      rdChk(`WPS_EVENT_PENDING_ONE, 16'h0003, 16'h0000);
      chk({15'h0000, intA}, 16'h0000);
      i_wps_far_end.frames(3'h5, 8'h1A, 1);
      chk({15'h0000, intA}, 16'h0001);
      rdChk(`WPS_PATH_STATUS_THREE, 16'h0002, 16'h0002);
      rdChk(`WPS_EVENT_PENDING_ONE, 16'h0003, 16'h0002);
      rdChk(`WPS_EVENT_PENDING_ONE, 16'h0003, 16'h0000);
      chk({15'h0000, intA}, 16'h0000);
      i_wps_far_end.frames(3'h2, 8'h1A, 10);
      chk({15'h0000, intB}, 16'h0001);
      rdChk(`WPS_PATH_STATUS_THREE, 16'h0001, 16'h0001);
      rdChk(`WPS_EVENT_PENDING_ONE, 16'h0001, 16'h0001);
      i_wps_far_end.frames(3'h6, 8'h1A, 10);
      chk({15'h0000, intA}, 16'h0001);
      rdChk(`WPS_EVENT_PENDING_TWO, 16'h0002, 16'h0002);
      i_wps_far_end.frames(3'h1, 8'h1A, 9);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0002, 16'h0002);
      i_wps_far_end.frames(3'h1, 8'h1A, 1);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0002, 16'h0000);
      wr(`WPS_PATH_MODE_CONTROL, 16'h0000);
      rdChk(`WPS_EVENT_PENDING_TWO, 16'h0003, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         i_wps_far_end.frames(3'h4, 8'h1A, 1);
         i_wps_far_end.frames(3'h7, 8'h1A, 1);
      end
      chk({15'h0000, intB}, 16'h0001);
      chk({15'h0000, intA}, 16'h0001);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0001, 16'h0001);
      rdChk(`WPS_EVENT_PENDING_TWO, 16'h0001, 16'h0001);
      i_wps_far_end.frames(3'h3, 8'h1A, 9);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0001, 16'h0001);
      i_wps_far_end.frames(3'h0, 8'h1A, 1);
      rdChk(`WPS_EVENT_LIVE_TWO, 16'h0001, 16'h0000);
      wrap_up;
   end
endmodule // wps_path_overhead_test
`default_nettype wire
